// ===== src/lgs_pkg.sv
// Shared constants for the general status and RTC configuration bank.
// Assumes a configuration-space access port with byte enables.
package lgs_pkg;
  // Register byte offsets
  localparam logic [7:0] LGS_GEN_STATUS_OFS = 8'hd4;
  localparam logic [7:0] LGS_RTC_RAM_CONFIGURATION_OFS = 8'hd8;
  // General status field positions
  localparam int LGS_SAFE_MODE_BIT = 2;
  localparam int LGS_NO_REBOOT_BIT = 1;
  localparam int LGS_RATIO_LSB = 8;
  localparam int LGS_SELFTEST_BIT = 12;
  localparam int LGS_SWAP_BIT = 13;
  // RTC configuration field positions
  localparam int LGS_UPPER_EN_BIT = 2;
  localparam int LGS_LOWER_LOCK_BIT = 3;
  localparam int LGS_UPPER_LOCK_BIT = 4;
  // Reset values
  localparam logic [3:0] LGS_RATIO_RESET = 4'hf;
  localparam logic [7:0] LGS_RTC_RAM_CONFIGURATION_RESET = 8'h00;
  // Locked window within a RTC RAM bank
  localparam logic [6:0] LGS_LOCK_LO = 7'h38;
  localparam logic [6:0] LGS_LOCK_HI = 7'h3f;
  // Firmware address bit that is inverted for swapped boot block
  localparam int LGS_SWAP_ADDR_BIT = 16;
  // Hold of the processor init line after reset release, in ns
  localparam int LGS_INIT_HOLD_NS = 40;
  localparam int LGS_CLK_NS = 10;
  localparam int LGS_INIT_HOLD_CYC = (LGS_INIT_HOLD_NS + LGS_CLK_NS - 1) / LGS_CLK_NS;
endpackage

// ===== src/lgs_if.sv
// Carrier between the bank and the RTC RAM access gate.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
interface lgs_ram_if;
  logic upperEnable;
  logic upperLock;
  logic lowerLock;
  modport bank (output upperEnable, output upperLock, output lowerLock);
  modport gate (input upperEnable, input upperLock, input lowerLock);
endinterface
`default_nettype wire

// ===== src/lgs_ram_gate.sv
// Gating of RTC CMOS RAM accesses by the bank enable and lock bits.
// Assumes requests from the RTC index/data logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module lgs_ram_gate
  import lgs_pkg::*;
(
  lgs_ram_if.gate cfg,
  input wire logic ramReq,
  input wire logic ramUpper,
  input wire logic [6:0] ramIndex,
  output logic ramAllow
);
  // ==========================================
  // Access decision
  wire inWindow = (ramIndex >= LGS_LOCK_LO) && (ramIndex <= LGS_LOCK_HI);
  wire upperOk = cfg.upperEnable && !(cfg.upperLock && inWindow);
  wire lowerOk = !(cfg.lowerLock && inWindow);
  assign ramAllow = ramReq && (ramUpper ? upperOk : lowerOk);
endmodule
`default_nettype wire

// ===== src/lgs_bank.sv
// General status and RTC configuration registers of the LPC bridge.
// Assumes strap pins and power_good arrive asynchronously; registers
// are reached through a config-space port with dword byte enables.
`timescale 1ns/1ns
`default_nettype none
module lgs_bank
  import lgs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic rtcRstn,
  input wire logic cfgWr,
  input wire logic cfgRd,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  input wire logic powerGood,
  input wire logic audioLinkOutPin,
  input wire logic speakerPin,
  input wire logic ratioStrapPin,
  input wire logic fwBiosCycle,
  input wire logic [31:0] fwAddrIn,
  output logic [31:0] fwAddrOut,
  input wire logic procResetReq,
  output logic hubResetCycle,
  output logic hubResetLevel,
  output logic processorResetLine,
  output logic processorInitLine,
  input wire logic watchdogSecondTimeout,
  output logic systemReboot,
  input wire logic ramReq,
  input wire logic ramUpper,
  input wire logic [6:0] ramIndex,
  output logic ramAllow
);
  // ==========================================
  // Pin synchronisers
  logic [1:0] pgSync_reg, audSync_reg, spkSync_reg, strapSync_reg;
  logic pgPrev_reg;
  always_ff @(posedge clk_sys) begin
    pgSync_reg <= {pgSync_reg[0], powerGood};
    audSync_reg <= {audSync_reg[0], audioLinkOutPin};
    spkSync_reg <= {spkSync_reg[0], speakerPin};
    strapSync_reg <= {strapSync_reg[0], ratioStrapPin};
    pgPrev_reg <= pgSync_reg[1];
  end
  wire pgRise = pgSync_reg[1] && !pgPrev_reg;

  // Marks that safe mode holds a captured value
  logic pgSeen_reg;
  always_ff @(posedge clk_sys) begin
    if (!rtcRstn) begin
      pgSeen_reg <= 1'b0;
    end else if (pgRise) begin
      pgSeen_reg <= 1'b1;
    end
  end

  // ==========================================
  // Register decode
  wire selGen = (cfgAddr == LGS_GEN_STATUS_OFS);
  wire selRtc = (cfgAddr == LGS_RTC_RAM_CONFIGURATION_OFS);
  wire wrGenLo = cfgWr && selGen && cfgByteEn[0];
  wire wrGenHi = cfgWr && selGen && cfgByteEn[1];
  wire wrRtc = cfgWr && selRtc && cfgByteEn[0];

  // ==========================================
  // Strap-captured flags
  logic safeMode_reg, noRebootStrap_reg, noReboot_reg;
  always_ff @(posedge clk_sys) begin
    if (pgRise) begin
      safeMode_reg <= audSync_reg[1];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      noRebootStrap_reg <= 1'b0;
      noReboot_reg <= 1'b0;
    end else if (pgRise) begin
      noRebootStrap_reg <= spkSync_reg[1];
      noReboot_reg <= spkSync_reg[1] | noReboot_reg;
    end else if (wrGenLo) begin
      // Zero write ignored while the strap holds the bit
      noReboot_reg <= cfgWrData[LGS_NO_REBOOT_BIT] | noRebootStrap_reg;
    end
  end

  // ==========================================
  // RTC-well bits: swap and ratio
  logic swap_reg;
  logic [3:0] ratio_reg;
  always_ff @(posedge clk_sys) begin
    if (!rtcRstn) begin
      swap_reg <= 1'b0;
      ratio_reg <= LGS_RATIO_RESET;
    end else begin
      if (wrGenHi) begin
        swap_reg <= cfgWrData[LGS_SWAP_BIT];
      end
      if (strapSync_reg[1]) begin
        ratio_reg <= LGS_RATIO_RESET;
      end else if (wrGenHi && !safeMode_reg) begin
        ratio_reg <= cfgWrData[LGS_RATIO_LSB +: 4];
      end
    end
  end
  wire [3:0] ratioEff = safeMode_reg ? LGS_RATIO_RESET : ratio_reg;

  // ==========================================
  // Core-well self-test enable
  logic selftest_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      selftest_reg <= 1'b0;
    end else if (wrGenHi) begin
      selftest_reg <= cfgWrData[LGS_SELFTEST_BIT];
    end
  end

  // ==========================================
  // RTC configuration
  logic upperEn_reg, upperLock_reg, lowerLock_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      upperEn_reg <= LGS_RTC_RAM_CONFIGURATION_RESET[LGS_UPPER_EN_BIT];
      upperLock_reg <= LGS_RTC_RAM_CONFIGURATION_RESET[LGS_UPPER_LOCK_BIT];
      lowerLock_reg <= LGS_RTC_RAM_CONFIGURATION_RESET[LGS_LOWER_LOCK_BIT];
    end else if (wrRtc) begin
      upperEn_reg <= cfgWrData[LGS_UPPER_EN_BIT];
      upperLock_reg <= upperLock_reg | cfgWrData[LGS_UPPER_LOCK_BIT];
      lowerLock_reg <= lowerLock_reg | cfgWrData[LGS_LOWER_LOCK_BIT];
    end
  end

  // ==========================================
  // Read mux, reserved bits zero
  logic [31:0] genView, rtcView;
  always_comb begin
    genView = 32'h0000_0000;
    genView[LGS_SWAP_BIT] = swap_reg;
    genView[LGS_SELFTEST_BIT] = selftest_reg;
    genView[LGS_RATIO_LSB +: 4] = ratioEff;
    genView[LGS_SAFE_MODE_BIT] = safeMode_reg;
    genView[LGS_NO_REBOOT_BIT] = noReboot_reg;
    rtcView = 32'h0000_0000;
    rtcView[LGS_UPPER_EN_BIT] = upperEn_reg;
    rtcView[LGS_UPPER_LOCK_BIT] = upperLock_reg;
    rtcView[LGS_LOWER_LOCK_BIT] = lowerLock_reg;
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cfgRdData <= 32'h0000_0000;
    end else if (cfgRd) begin
      cfgRdData <= selGen ? genView : (selRtc ? rtcView : 32'h0000_0000);
    end
  end

  // ==========================================
  // Firmware address swap
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fwAddrOut <= 32'h0000_0000;
    end else begin
      fwAddrOut <= fwAddrIn;
      if (fwBiosCycle && swap_reg) begin
        fwAddrOut[LGS_SWAP_ADDR_BIT] <= ~fwAddrIn[LGS_SWAP_ADDR_BIT];
      end
    end
  end

  // ==========================================
  // Processor reset via hub cycle, init with hold
  logic [7:0] hold_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hubResetLevel <= 1'b1;
      hubResetCycle <= 1'b0;
      processorInitLine <= 1'b0;
      hold_reg <= 8'h00;
    end else begin
      hubResetCycle <= (procResetReq != hubResetLevel);
      hubResetLevel <= procResetReq;
      if (hubResetLevel && selftest_reg) begin
        processorInitLine <= 1'b1;
        hold_reg <= 8'(LGS_INIT_HOLD_CYC);
      end else if (hold_reg != 8'h00) begin
        hold_reg <= hold_reg - 8'h01;
      end else begin
        processorInitLine <= 1'b0;
      end
    end
  end
  assign processorResetLine = hubResetLevel;

  // ==========================================
  // Watchdog reboot gate
  assign systemReboot = watchdogSecondTimeout && !noReboot_reg;

  // ==========================================
  // RTC RAM gate
  lgs_ram_if ramCfg ();
  assign ramCfg.upperEnable = upperEn_reg;
  assign ramCfg.upperLock = upperLock_reg;
  assign ramCfg.lowerLock = lowerLock_reg;
  lgs_ram_gate gate (
    .cfg(ramCfg.gate),
    .ramReq(ramReq),
    .ramUpper(ramUpper),
    .ramIndex(ramIndex),
    .ramAllow(ramAllow)
  );

  // ==========================================
  // Checks, grouped by the bit that they guard

  // Safe mode forces the ratio view to all ones
  ratio_safe_a: assert property (@(posedge clk_sys) disable iff (!rtcRstn)
    safeMode_reg |-> ratioEff == LGS_RATIO_RESET)
    else $error("ratio not forced");

  // Ratio field frozen while safe mode is set and the strap pin is low
  ratio_lock_a: assert property (@(posedge clk_sys) disable iff (!rtcRstn)
    (safeMode_reg && !strapSync_reg[1]) |=> $stable(ratio_reg))
    else $error("ratio written in safe mode");

  // Ratio field takes the write outside safe mode
  ratio_write_a: assert property (@(posedge clk_sys) disable iff (!rtcRstn)
    (wrGenHi && !safeMode_reg && !strapSync_reg[1]) |=> ratio_reg == $past(cfgWrData[11:8]))
    else $error("ratio write lost");

  // RTC-well reset returns ratio to all ones
  ratio_rtc_a: assert property (@(posedge clk_sys)
    !rtcRstn |=> ratio_reg == LGS_RATIO_RESET)
    else $error("ratio not reset");

  // Strap pin returns ratio to all ones
  strap_pin_a: assert property (@(posedge clk_sys) disable iff (!rtcRstn)
    strapSync_reg[1] |=> ratio_reg == LGS_RATIO_RESET)
    else $error("ratio strap ignored");

  // Swap bit cleared by RTC-well reset
  swap_clear_a: assert property (@(posedge clk_sys)
    !rtcRstn |=> !swap_reg)
    else $error("swap not cleared");

  // Safe flag captures the audio pin at power-good rise
  safe_capture_a: assert property (@(posedge clk_sys)
    pgRise |=> safeMode_reg == $past(audSync_reg[1]))
    else $error("safe flag not captured");

  // Safe flag moves only at power-good rise
  safe_hold_a: assert property (@(posedge clk_sys) disable iff (!pgSeen_reg)
    !$past(pgRise) |-> $stable(safeMode_reg))
    else $error("safe flag moved");

  // Inhibit set suppresses reboot
  reboot_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    noReboot_reg |-> !systemReboot)
    else $error("reboot leaked");

  // Inhibit clear lets the second timeout reboot
  reboot_pass_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (watchdogSecondTimeout && !noReboot_reg) |-> systemReboot)
    else $error("reboot missing");

  // Speaker strap sets inhibit at power-good rise
  noreboot_strap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pgRise && spkSync_reg[1]) |=> noReboot_reg)
    else $error("inhibit strap missed");

  // Software one sets inhibit
  noreboot_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrGenLo && cfgWrData[LGS_NO_REBOOT_BIT] && !pgRise) |=> noReboot_reg)
    else $error("inhibit write lost");

  // Strap holds inhibit against zero writes
  strap_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    noRebootStrap_reg && noReboot_reg |=> noReboot_reg)
    else $error("inhibit cleared");

  // Upper lock is write-once
  lock_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    upperLock_reg |=> upperLock_reg)
    else $error("upper lock dropped");

  // Lower lock is write-once
  lower_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    lowerLock_reg |=> lowerLock_reg)
    else $error("lower lock dropped");

  // Swapped BIOS cycle inverts the address bit
  swap_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (fwBiosCycle && swap_reg) |=> fwAddrOut[LGS_SWAP_ADDR_BIT] != $past(fwAddrIn[16]))
    else $error("swap missed");

  // Other cycles pass the address untouched
  swap_pass_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(fwBiosCycle && swap_reg) |=> fwAddrOut == $past(fwAddrIn))
    else $error("address altered");

  // Reset level change issues one hub cycle
  hub_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (procResetReq != hubResetLevel) |=> hubResetCycle)
    else $error("hub cycle missing");

  // Init follows processor reset under self-test
  init_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (hubResetLevel && selftest_reg) |=> processorInitLine)
    else $error("init not driven");

  // Init released once the hold has run out
  init_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!hubResetLevel && hold_reg == 8'h00) |=> !processorInitLine)
    else $error("init stuck");

  // Upper bank closed while disabled
  upper_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ramUpper && !upperEn_reg) |-> !ramAllow)
    else $error("upper bank open");

  // Upper lock closes its window
  upper_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ramUpper && upperLock_reg && ramIndex >= LGS_LOCK_LO && ramIndex <= LGS_LOCK_HI) |-> !ramAllow)
    else $error("upper window open");

  // Lower lock closes its window
  lower_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!ramUpper && lowerLock_reg && ramIndex >= LGS_LOCK_LO && ramIndex <= LGS_LOCK_HI) |-> !ramAllow)
    else $error("lower window open");

  // Reserved status bits read zero
  rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cfgRd && selGen) |=> (cfgRdData[31:14] == 18'h0 && cfgRdData[7:3] == 5'h00 && !cfgRdData[0]))
    else $error("reserved bit set");

  // Unmapped offsets read zero
  unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cfgRd && !selGen && !selRtc) |=> cfgRdData == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the general status and RTC configuration bank.
// Assumes lgs_pkg, lgs_if, lgs_ram_gate and lgs_bank are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, want) begin checks++; if ((got) !== (want)) begin nMismatch++; \
  $display("[ERR] %0t got %h want %h", $time, got, want); end end
module tb
  import lgs_pkg::*;
;
  // ==========================================================
  // Signals and design
  typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] wd; logic [31:0] rd;} lgs_row_t;
  logic clk_sys = 1'b0, rstn = 1'b0, rtcRstn = 1'b0, cfgWr = 1'b0, cfgRd = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [3:0] cfgByteEn = 4'h0;
  logic [31:0] cfgWrData = 32'h0, fwAddrIn = 32'h0, cfgRdData, fwAddrOut;
  logic powerGood = 1'b0, audioLinkOutPin = 1'b0, speakerPin = 1'b0, ratioStrapPin = 1'b0;
  logic fwBiosCycle = 1'b0, procResetReq = 1'b0, watchdogSecondTimeout = 1'b0;
  logic ramReq = 1'b1, ramUpper = 1'b0;
  logic [6:0] ramIndex = 7'h00;
  logic hubResetCycle, processorResetLine, processorInitLine, systemReboot, ramAllow;
  int nMismatch = 0, checks = 0, hubPulses = 0, p0;
  // Ordinary register cases: offset, lanes, write data, read back
  lgs_row_t rows[6] = '{
    '{8'hd4, 4'hf, 32'hffff_ffff, 32'h0000_3f02},
    '{8'hd4, 4'hf, 32'h0000_0500, 32'h0000_0500},
    '{8'hd4, 4'h1, 32'h0000_00ff, 32'h0000_0502},
    '{8'hd4, 4'h2, 32'h0000_3a00, 32'h0000_3a02},
    '{8'hd8, 4'h1, 32'h0000_00e7, 32'h0000_0004},
    '{8'hd0, 4'hf, 32'hffff_ffff, 32'h0000_0000}};

  lgs_bank dut (.clk_sys(clk_sys), .rstn(rstn), .rtcRstn(rtcRstn), .cfgWr(cfgWr),
    .cfgRd(cfgRd), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .powerGood(powerGood), .audioLinkOutPin(audioLinkOutPin),
    .speakerPin(speakerPin), .ratioStrapPin(ratioStrapPin), .fwBiosCycle(fwBiosCycle),
    .fwAddrIn(fwAddrIn), .fwAddrOut(fwAddrOut), .procResetReq(procResetReq),
    .hubResetCycle(hubResetCycle), .hubResetLevel(),
    .processorResetLine(processorResetLine), .processorInitLine(processorInitLine),
    .watchdogSecondTimeout(watchdogSecondTimeout), .systemReboot(systemReboot),
    .ramReq(ramReq), .ramUpper(ramUpper), .ramIndex(ramIndex), .ramAllow(ramAllow));

  // Clock and special cycle counter
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (hubResetCycle === 1'b1) begin
      hubPulses++;
    end
  end

  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cyc(1);
    {cfgWr, cfgAddr, cfgByteEn, cfgWrData} = {1'b1, a, be, d};
    cyc(1);
    cfgWr = 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] want,
      input logic [31:0] m = 32'hffff_ffff);
    cyc(1);
    {cfgRd, cfgAddr} = {1'b1, a};
    cyc(1);
    cfgRd = 1'b0;
    `CHK(cfgRdData & m, want)
  endtask
  task automatic rst(input logic core, input logic rtc);
    {rstn, rtcRstn} = {~core, ~rtc};
    cyc(3);
    {rstn, rtcRstn} = 2'b11;
  endtask
  // Power-good rise with chosen strap levels
  task automatic pg(input logic aud, input logic spk);
    {powerGood, audioLinkOutPin, speakerPin} = {1'b0, aud, spk};
    cyc(4);
    powerGood = 1'b1;
    cyc(6);
  endtask
  task automatic ram(input logic up, input logic [6:0] idx, input logic want);
    {ramUpper, ramIndex} = {up, idx};
    #1 `CHK(ramAllow, want)
  endtask
  task automatic fw(input logic bios, input logic [31:0] want);
    {fwBiosCycle, fwAddrIn} = {bios, 32'h0001_2345};
    cyc(1);
    `CHK(fwAddrOut, want)
  endtask
  task automatic complete_run();
    if (nMismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    #30000;
    nMismatch++;
    complete_run();
  end
  initial begin
    rst(1'b1, 1'b1);
    pg(1'b0, 1'b0);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_0f00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].be, rows[i].wd);
      chk_rd(rows[i].a, rows[i].rd);
    end
    fw(1'b1, 32'h0000_2345);
    fw(1'b0, 32'h0001_2345);
    watchdogSecondTimeout = 1'b1;
    #1 `CHK(systemReboot, 1'b0)
    wr(LGS_GEN_STATUS_OFS, 4'h1, 32'h0);
    #1 `CHK(systemReboot, 1'b1)
    // Self-test init follows processor reset, then holds
    p0 = hubPulses;
    procResetReq = 1'b1;
    cyc(3);
    `CHK({processorResetLine, processorInitLine}, 2'b11)
    procResetReq = 1'b0;
    cyc(2);
    `CHK({processorResetLine, processorInitLine}, 2'b01)
    cyc(LGS_INIT_HOLD_CYC + 1);
    `CHK(processorInitLine, 1'b0)
    `CHK(hubPulses - p0, 2)
    wr(LGS_GEN_STATUS_OFS, 4'h2, 32'h0000_2a00);
    procResetReq = 1'b1;
    cyc(3);
    `CHK(processorInitLine, 1'b0)
    procResetReq = 1'b0;
    // Ratio strap pin, then core and RTC-well resets
    ratioStrapPin = 1'b1;
    cyc(4);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_2f00);
    ratioStrapPin = 1'b0;
    cyc(4);
    wr(LGS_GEN_STATUS_OFS, 4'h2, 32'h0000_3500);
    rst(1'b1, 1'b0);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_2500);
    rst(1'b0, 1'b1);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_0f00);
    // RTC RAM gating by enable and locks
    ram(1'b1, 7'h10, 1'b0);
    ram(1'b0, 7'h38, 1'b1);
    wr(LGS_RTC_RAM_CONFIGURATION_OFS, 4'h1, 32'h0000_000c);
    ram(1'b1, 7'h38, 1'b1);
    ram(1'b0, 7'h38, 1'b0);
    ram(1'b0, 7'h3f, 1'b0);
    ram(1'b0, 7'h37, 1'b1);
    ram(1'b0, 7'h40, 1'b1);
    wr(LGS_RTC_RAM_CONFIGURATION_OFS, 4'h1, 32'h0000_001c);
    ram(1'b1, 7'h3f, 1'b0);
    ram(1'b1, 7'h37, 1'b1);
    wr(LGS_RTC_RAM_CONFIGURATION_OFS, 4'h1, 32'h0);
    chk_rd(LGS_RTC_RAM_CONFIGURATION_OFS, 32'h0000_0018);
    rst(1'b1, 1'b0);
    chk_rd(LGS_RTC_RAM_CONFIGURATION_OFS, 32'h0);
    // Safe mode and no-reboot straps
    pg(1'b1, 1'b1);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_0f06, 32'h0000_0f06);
    wr(LGS_GEN_STATUS_OFS, 4'h3, 32'h0);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_0f06, 32'h0000_0f06);
    `CHK(systemReboot, 1'b0)
    rst(1'b1, 1'b1);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_0f04, 32'h0000_0f04);
    pg(1'b0, 1'b0);
    wr(LGS_GEN_STATUS_OFS, 4'h2, 32'h0000_0300);
    chk_rd(LGS_GEN_STATUS_OFS, 32'h0000_0300);
    complete_run();
  end
endmodule
`default_nettype wire
